//--- logic/sac_dev.sv
/*
 * digital side of a 16-bit successive-approximation converter:
 * conversion timing, nap, shutdown, reset pin and the output bus.
 * assumes the host drives all link pins; they are synchronised here.
 */
// Behaviour
// - falling start edge starts; no restart mid-conversion
// - busy high exactly while converting
// - host raises start within 40ns or after
// - host keeps data lines quiet before start
// - conversion ends within 310ns, internally timed
// - 77ns acquisition gives 2.5Msps parallel throughput
// - start held low naps; 200ns high exits
// - power-down off, conversion requests ignored
// - power-down mid-conversion finishes first; read later
// - host reads result before power-down
// - host releases power-down, waits 5ms
// - power-on reset reinitialises; first result valid
// - mode 0, byte 0: full word
// - chip select high releases the bus
// - byte select picks byte on upper pins
// - lower pins carry opposite byte
// - mode 1: serial out, byte select ignored
// - serial bit changes after rising, msb held
// - reset pin aborts, releases bus, ignores starts
module sac_dev
   import sac_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   sac_link_if.dev                link,
   input  wire logic [DATA_W-1:0] sample_in,
   output logic                   conv_done,
   output logic                   napping,
   output logic                   shut_down
);
   typedef enum logic [3:0] {
      ST_ACQ  = 4'b0001,
      ST_CONV = 4'b0010,
      ST_NAP  = 4'b0100,
      ST_SHUT = 4'b1000
   } sac_dstate_type;

   // bus word for the parallel modes; byte select swaps the halves
   function automatic logic [15:0] par_word(input logic [15:0] r,
                                            input logic        bsel);
      return bsel ? {r[7:0], r[15:8]} : r;
   endfunction : par_word

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: cnv, pd, rst, mode, bsel, cs_n, sck
   logic [6:0] sync1_r;
   logic [6:0] sync2_r;
   logic [1:0] prev_r;

   // pins idle in their inactive levels after reset
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_r <= 7'h21;
         sync2_r <= 7'h21;
         prev_r  <= 2'h1;
      end else begin
         sync1_r <= {link.sck, link.cs_n, link.byte_select_addr,
                     link.bus_mode_select, link.reset_pin,
                     link.power_down_pin, link.convert_start_n};
         sync2_r <= sync1_r;
         prev_r  <= {sync2_r[6], sync2_r[0]};
      end
   end

   logic cnv_s, pd_s, rst_s, mode_s, bsel_s, csn_s, sck_s;
   assign {sck_s, csn_s, bsel_s, mode_s, rst_s, pd_s, cnv_s} = sync2_r;

   logic start_fall, sck_rise, sck_fall;
   assign start_fall = prev_r[0] & ~cnv_s;
   assign sck_rise   = ~prev_r[1] & sck_s;
   assign sck_fall   = prev_r[1] & ~sck_s;

   ////////////////////////////////////////////////////////////////////////
   // conversion state, result and output bus
   sac_dstate_type state_r, state_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   logic [3:0]  hi_r, hi_nxt;
   logic [15:0] result_r, result_nxt;
   logic [15:0] shreg_r, shreg_nxt;
   logic        seen_fall_r, seen_fall_nxt;
   logic        busy_r, busy_nxt;
   logic        done_r, done_nxt;
   logic [15:0] dout_r, dout_nxt;
   logic [15:0] doe_r, doe_nxt;

   // next-state for conversion control and pins
   always_comb begin
      state_nxt     = state_r;
      cnt_nxt       = cnt_r;
      result_nxt    = result_r;
      shreg_nxt     = shreg_r;
      seen_fall_nxt = seen_fall_r;
      busy_nxt      = busy_r;
      done_nxt      = 1'b0;
      dout_nxt      = dout_r;
      doe_nxt       = 16'h0000;

      // high time of the start pin, saturating; judges nap exit
      if (!cnv_s) begin
         hi_nxt = 4'h0;
      end else if (hi_r < 4'(NAP_CYC)) begin
         hi_nxt = hi_r + 4'h1;
      end else begin
         hi_nxt = hi_r;
      end

      // serial shift: msb holds until a rise after the first fall
      if (sck_fall) begin
         seen_fall_nxt = 1'b1;
      end
      if (sck_rise && seen_fall_r) begin
         shreg_nxt = {shreg_r[14:0], 1'b0};
      end

      unique case (state_r)
         ST_ACQ: begin
            if (pd_s) begin
               state_nxt = ST_SHUT;
            end else if (start_fall) begin
               state_nxt = ST_CONV;
               cnt_nxt   = 4'h0;
               busy_nxt  = 1'b1;
            end
         end
         ST_CONV: begin
            // further start edges are ignored here
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == 4'(CONV_CYC - 1)) begin
               busy_nxt      = 1'b0;
               done_nxt      = 1'b1;
               result_nxt    = sample_in;
               shreg_nxt     = sample_in;
               seen_fall_nxt = 1'b0;
               // shutdown only once the conversion has finished
               if (pd_s) begin
                  state_nxt = ST_SHUT;
               end else if (!cnv_s) begin
                  state_nxt = ST_NAP;
               end else begin
                  state_nxt = ST_ACQ;
               end
            end
         end
         ST_NAP: begin
            // a start edge after a too-short high pulse is dropped
            if (pd_s) begin
               state_nxt = ST_SHUT;
            end else if (start_fall && hi_r >= 4'(NAP_CYC)) begin
               state_nxt = ST_CONV;
               cnt_nxt   = 4'h0;
               busy_nxt  = 1'b1;
            end
         end
         ST_SHUT: begin
            if (!pd_s) begin
               state_nxt = ST_ACQ;
            end
         end
      endcase

      // output bus; released in shutdown and while deselected
      if (!csn_s && state_r != ST_SHUT) begin
         if (mode_s) begin
            doe_nxt[SDO_BIT]  = 1'b1;
            dout_nxt          = 16'h0000;
            dout_nxt[SDO_BIT] = shreg_r[15];
         end else begin
            doe_nxt  = 16'hffff;
            dout_nxt = par_word(result_r, bsel_s);
         end
      end

      // reset pin wins over all but the done pulse and result load of an ending conversion: abort and release the bus
      if (rst_s) begin
         state_nxt = ST_ACQ;
         cnt_nxt   = 4'h0;
         busy_nxt  = 1'b0;
         doe_nxt   = 16'h0000;
      end
   end

   // power-on reset puts every piece in a known idle state
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r     <= ST_ACQ;
         cnt_r       <= 4'h0;
         hi_r        <= 4'h0;
         result_r    <= 16'h0000;
         shreg_r     <= 16'h0000;
         seen_fall_r <= 1'b0;
         busy_r      <= 1'b0;
         done_r      <= 1'b0;
         dout_r      <= 16'h0000;
         doe_r       <= 16'h0000;
      end else begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         hi_r        <= hi_nxt;
         result_r    <= result_nxt;
         shreg_r     <= shreg_nxt;
         seen_fall_r <= seen_fall_nxt;
         busy_r      <= busy_nxt;
         done_r      <= done_nxt;
         dout_r      <= dout_nxt;
         doe_r       <= doe_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status outputs, each straight from a flop
   logic nap_r, shut_r;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         nap_r  <= 1'b0;
         shut_r <= 1'b0;
      end else begin
         nap_r  <= (state_nxt == ST_NAP);
         shut_r <= (state_nxt == ST_SHUT);
      end
   end

   assign link.busy     = busy_r;
   assign link.data_out = dout_r;
   assign link.data_oe  = doe_r;
   assign conv_done     = done_r;
   assign napping       = nap_r;
   assign shut_down     = shut_r;
endmodule : sac_dev

//--- logic/sac_host.sv
/*
 * host controller for the converter link, ordered over apb.
 * assumes software polls status; no wait states on the bus.
 */
// Register access over APB and the placing of the registers were decided locally.
module sac_host
   import sac_pkg::*;
#(
   parameter int REC_CYC = PD_REC_CYC
)(
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   sac_link_if.host         link
);
   typedef enum logic [8:0] {
      H_IDLE = 9'b000000001, H_PREP = 9'b000000010,
      H_LOW  = 9'b000000100, H_WHI  = 9'b000001000,
      H_WLO  = 9'b000010000, H_PAR  = 9'b000100000,
      H_SER  = 9'b001000000, H_PD   = 9'b010000000,
      H_REC  = 9'b100000000
   } sac_hstate_type;

   ////////////////////////////////////////////////////////////////////////
   // link input synchronisers
   logic [17:0] s1_r, s2_r;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_r <= 18'h0;
         s2_r <= 18'h0;
      end else begin
         s1_r <= {link.busy, link.serial_data_out, link.data_bus};
         s2_r <= s1_r;
      end
   end
   logic        busy_s, sdo_s;
   logic [15:0] data_s;
   assign {busy_s, sdo_s, data_s} = s2_r;

   ////////////////////////////////////////////////////////////////////////
   // registers and sequencing
   sac_hstate_type st_r, st_nxt;
   logic [16:0] cnt_r, cnt_nxt;
   logic [4:0]  bits_r, bits_nxt;
   logic [5:0]  ctrl_r, ctrl_nxt;
   logic [15:0] res_r, res_nxt;
   logic        pend_r, pend_nxt, val_r, val_nxt, err_r, err_nxt;
   logic        cnv_r, cnv_nxt, pd_r, pd_nxt, bsel_r, bsel_nxt;
   logic        cs_r, cs_nxt, sck_r, sck_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic        slv_r, slv_nxt, rdy_r;
   logic        wr_acc, rd_set, hit;

   assign wr_acc = psel & penable & pwrite;
   assign rd_set = psel & ~penable & ~pwrite;
   assign hit    = paddr == REG_CTRL || paddr == REG_STAT || paddr == REG_DATA;

   // next values: bus answers, command flags and the link sequence
   always_comb begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r + 17'h1;
      bits_nxt = bits_r;
      ctrl_nxt = ctrl_r;
      res_nxt  = res_r;
      pend_nxt = pend_r;
      val_nxt  = val_r;
      err_nxt  = err_r;
      cnv_nxt  = cnv_r;
      pd_nxt   = pd_r;
      bsel_nxt = bsel_r;
      cs_nxt   = cs_r;
      sck_nxt  = sck_r;
      rd_nxt   = rd_r;
      slv_nxt  = 1'b0;

      // read data is prepared in the setup cycle; reads clear flags
      if (psel && !penable) begin
         slv_nxt = ~hit;
         rd_nxt  = 32'h0;
         if (paddr == REG_CTRL) rd_nxt[5:0] = ctrl_r;
         if (paddr == REG_DATA) rd_nxt[15:0] = res_r;
         if (paddr == REG_STAT) begin
            rd_nxt[STAT_IDLE]  = st_r == H_IDLE;
            rd_nxt[STAT_VALID] = val_r;
            rd_nxt[STAT_ERR]   = err_r;
            rd_nxt[STAT_PEND]  = pend_r;
            rd_nxt[STAT_SHUT]  = st_r == H_PD || st_r == H_REC;
         end
      end
      if (rd_set && paddr == REG_DATA) val_nxt = 1'b0;
      if (rd_set && paddr == REG_STAT) err_nxt = 1'b0;
      if (wr_acc && paddr == REG_CTRL) begin
         ctrl_nxt = pwdata[5:0];
         ctrl_nxt[CTRL_START] = 1'b0;
         if (pwdata[CTRL_START]) pend_nxt = 1'b1;
      end

      unique case (st_r)
         H_IDLE: begin
            cnv_nxt = ~ctrl_r[CTRL_NAP];
            if (ctrl_r[CTRL_PD]) begin
               pd_nxt = 1'b1;
               st_nxt = H_PD;
            end else if (pend_r && !ctrl_r[CTRL_DEVRST]) begin
               pend_nxt = 1'b0;
               cnv_nxt  = 1'b1;
               cnt_nxt  = 17'h0;
               st_nxt   = H_PREP;
            end
         end
         H_PREP: begin
            // chip select stays high, so data lines are quiet here
            if (cnt_r >= 17'(ctrl_r[CTRL_NAP] ? NAP_CYC : ACQ_CYC) - 17'h1) begin
               cnv_nxt = 1'b0;
               cnt_nxt = 17'h0;
               st_nxt  = H_LOW;
            end
         end
         H_LOW: begin
            if (cnt_r >= 17'(START_LOW_CYC - 1)) begin
               cnv_nxt = ctrl_r[CTRL_NAP] ? 1'b0 : 1'b1;
               cnt_nxt = 17'h0;
               st_nxt  = H_WHI;
            end
         end
         H_WHI: begin
            if (busy_s) begin
               st_nxt = H_WLO;
            end else if (cnt_r >= 17'(BUSY_TIMEOUT)) begin
               err_nxt = 1'b1;
               st_nxt  = H_IDLE;
            end
         end
         H_WLO: begin
            if (!busy_s) begin
               cs_nxt   = 1'b0;
               cnt_nxt  = 17'h0;
               bits_nxt = 5'h0;
               st_nxt   = ctrl_r[CTRL_SERIAL] ? H_SER : H_PAR;
            end
         end
         H_PAR: begin
            if (cnt_r >= 17'(READ_WAIT - 1)) begin
               cnt_nxt = 17'h0;
               if (!ctrl_r[CTRL_BYTE]) begin
                  res_nxt = data_s;
                  st_nxt  = H_IDLE;
               end else if (!bsel_r) begin
                  res_nxt[15:8] = data_s[15:8];
                  bsel_nxt      = 1'b1;
               end else begin
                  res_nxt[7:0] = data_s[15:8];
                  bsel_nxt     = 1'b0;
                  st_nxt       = H_IDLE;
               end
               if (st_nxt == H_IDLE) begin
                  val_nxt = 1'b1;
                  cs_nxt  = 1'b1;
               end
            end
         end
         H_SER: begin
            // sample on each falling edge, after the bit has settled
            if (cnt_r >= 17'(SCK_HALF - 1)) begin
               cnt_nxt = 17'h0;
               sck_nxt = ~sck_r;
               if (sck_r) begin
                  res_nxt  = {res_r[14:0], sdo_s};
                  bits_nxt = bits_r + 5'h1;
                  if (bits_r == 5'(DATA_W - 1)) begin
                     val_nxt = 1'b1;
                     cs_nxt  = 1'b1;
                     st_nxt  = H_IDLE;
                  end
               end
            end
         end
         H_PD: begin
            if (!ctrl_r[CTRL_PD]) begin
               pd_nxt  = 1'b0;
               cnt_nxt = 17'h0;
               st_nxt  = H_REC;
            end
         end
         H_REC: begin
            if (cnt_r >= 17'(REC_CYC - 1)) st_nxt = H_IDLE;
         end
      endcase
   end

   // register every piece of state; pready stays high after reset
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r   <= H_IDLE;
         cnt_r  <= 17'h0;
         bits_r <= 5'h0;
         ctrl_r <= CTRL_RST;
         res_r  <= 16'h0;
         pend_r <= 1'b0;
         val_r  <= 1'b0;
         err_r  <= 1'b0;
         cnv_r  <= 1'b1;
         pd_r   <= 1'b0;
         bsel_r <= 1'b0;
         cs_r   <= 1'b1;
         sck_r  <= 1'b0;
         rd_r   <= 32'h0;
         slv_r  <= 1'b0;
         rdy_r  <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         bits_r <= bits_nxt;
         ctrl_r <= ctrl_nxt;
         res_r  <= res_nxt;
         pend_r <= pend_nxt;
         val_r  <= val_nxt;
         err_r  <= err_nxt;
         cnv_r  <= cnv_nxt;
         pd_r   <= pd_nxt;
         bsel_r <= bsel_nxt;
         cs_r   <= cs_nxt;
         sck_r  <= sck_nxt;
         rd_r   <= rd_nxt;
         slv_r  <= slv_nxt;
         rdy_r  <= 1'b1;
      end
   end

   assign prdata                = rd_r;
   assign pready                = rdy_r;
   assign pslverr               = slv_r;
   assign link.convert_start_n  = cnv_r;
   assign link.power_down_pin   = pd_r;
   assign link.reset_pin        = ctrl_r[CTRL_DEVRST];
   assign link.bus_mode_select  = ctrl_r[CTRL_SERIAL];
   assign link.byte_select_addr = bsel_r;
   assign link.cs_n             = cs_r;
   assign link.sck              = sck_r;
endmodule : sac_host

//--- logic/sac_link_if.sv
/*
 * pins between converter and host controller.
 * the data bus is resolved here from the device's output enables.
 */
interface sac_link_if;
   logic        convert_start_n;
   logic        power_down_pin;
   logic        reset_pin;
   logic        bus_mode_select;
   logic        byte_select_addr;
   logic        cs_n;
   logic        sck;
   logic        busy;
   logic [15:0] data_out;
   logic [15:0] data_oe;
   wire  [15:0] data_bus;
   wire         serial_data_out;

   // released bits read high, as through a pull-up; keeps unknowns off the bus
   for (genvar i = 0; i < 16; i++) begin : g_bus
      assign data_bus[i] = data_oe[i] ? data_out[i] : 1'b1;
   end
   assign serial_data_out = data_bus[10];

   modport dev (input convert_start_n, power_down_pin, reset_pin,
                bus_mode_select, byte_select_addr, cs_n, sck,
                output busy, data_out, data_oe);
   modport host (output convert_start_n, power_down_pin, reset_pin,
                 bus_mode_select, byte_select_addr, cs_n, sck,
                 input busy, data_bus, serial_data_out);
endinterface : sac_link_if

//--- logic/sac_pkg.sv
/*
 * shared constants of the converter link: pin timing, data layout,
 * controller register map and field positions.
 * assumes a single 25 MHz core clock at both ends of the link.
 */
package sac_pkg;
   ////////////////////////////////////////////////////////////////////////
   // clock and documented times
   localparam int CLK_NS          = 40;
   localparam int T_CONV_MAX_NS   = 310;
   localparam int T_ACQ_MIN_NS    = 77;
   localparam int T_NAP_EXIT_NS   = 200;
   localparam int T_START_HI_NS   = 40;
   localparam int T_PD_REC_NS     = 5000000;

   // least times round up, longest times round down, never below one
   function automatic int cyc_min(input int ns);
      return (ns + CLK_NS - 1) / CLK_NS;
   endfunction : cyc_min
   function automatic int cyc_max(input int ns);
      return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
   endfunction : cyc_max

   localparam int CONV_CYC       = cyc_max(T_CONV_MAX_NS);
   localparam int ACQ_CYC        = cyc_min(T_ACQ_MIN_NS);
   localparam int NAP_CYC        = cyc_min(T_NAP_EXIT_NS);
   localparam int START_LOW_CYC  = cyc_max(T_START_HI_NS);
   localparam int PD_REC_CYC     = cyc_min(T_PD_REC_NS);

   ////////////////////////////////////////////////////////////////////////
   // link layout and controller pacing
   localparam int DATA_W         = 16;
   localparam int SDO_BIT        = 10;
   localparam int SCK_HALF       = 8;
   localparam int READ_WAIT      = 6;
   localparam int BUSY_TIMEOUT   = 15;

   ////////////////////////////////////////////////////////////////////////
   // controller registers, byte addresses on apb
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam int CTRL_START     = 0;
   localparam int CTRL_PD        = 1;
   localparam int CTRL_SERIAL    = 2;
   localparam int CTRL_BYTE      = 3;
   localparam int CTRL_NAP       = 4;
   localparam int CTRL_DEVRST    = 5;
   localparam int STAT_IDLE      = 0;
   localparam int STAT_VALID     = 1;
   localparam int STAT_ERR       = 2;
   localparam int STAT_PEND      = 3;
   localparam int STAT_SHUT      = 4;
endpackage : sac_pkg

//--- sim/sac_link_assertions.sv
/* checker of the converter link: busy timing, bus release and byte views.
   assumes the signals of one interface that joins device and host. */
module sac_link_assertions (
   input wire logic        core_clk,
   input wire logic        arst_n,
   input wire logic        convert_start_n,
   input wire logic        power_down_pin,
   input wire logic        reset_pin,
   input wire logic        bus_mode_select,
   input wire logic        byte_select_addr,
   input wire logic        cs_n,
   input wire logic        busy,
   input wire logic [15:0] data_out,
   input wire logic [15:0] data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////
   // last word with its bytes swapped, for the byte select check
   logic [15:0] swap_r;
   logic [15:0] swap_nxt;
   always_comb begin
      swap_nxt = {data_out[7:0], data_out[15:8]};
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) swap_r <= 16'h0000;
      else swap_r <= swap_nxt;
   end
   ////////////////////////////////////////////////////////////////////////
   // a late start edge must not stretch busy past seven cycles
   // the reset pin may cut a conversion short, so it disables this check
   chk_busy_len: assert property (
      disable iff (!arst_n || reset_pin)
      $rose(busy) |-> busy[*7] ##1 !busy) else $error("busy length wrong");
   chk_start_busy: assert property (
      $fell(convert_start_n) && !busy && !power_down_pin && !reset_pin
      && !$past(reset_pin, 4) |-> ##[1:4] busy) else $error("start not taken");
   chk_pd_ignore: assert property (
      power_down_pin && $past(power_down_pin, 4) |-> !$rose(busy))
      else $error("start taken in shutdown");
   chk_reset_abort: assert property (
      reset_pin[*5] |-> !busy && data_oe == 16'h0000) else $error("reset pin ignored");
   chk_cs_release: assert property (
      cs_n[*5] |-> data_oe == 16'h0000) else $error("bus driven while deselected");
   chk_word_drive: assert property (
      (!cs_n && !bus_mode_select && !reset_pin && !power_down_pin)[*5]
      |-> data_oe == 16'hffff) else $error("parallel bus not driven");
   chk_serial_pin: assert property (
      (!cs_n && bus_mode_select && !reset_pin && !power_down_pin)[*5]
      |-> data_oe == 16'h0400) else $error("serial mode drives wrong pins");
   chk_byte_swap: assert property (
      $rose(byte_select_addr) && !bus_mode_select && !cs_n && !busy
      |-> ##4 data_out == $past(swap_r, 3)) else $error("byte views not swapped");
   // main scenarios reached
   cov_conv: cover property ($rose(busy));
   cov_serial: cover property ($fell(cs_n) && bus_mode_select);
   cov_byte: cover property ($rose(byte_select_addr) && !cs_n);
   cov_reset: cover property (reset_pin && busy);
endmodule : sac_link_assertions

//--- sim/tb_sar_adc_conversion_and_readout.sv
/* bench: apb orders to the host controller, which runs the converter.
   assumes the designer's package, link interface and both ends. */
module tb_sar_adc_conversion_and_readout
   import sac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] sample_in = 16'h0000;
   logic        conv_done;
   logic        napping;
   logic        shut_down;
   logic [31:0] rd;
   logic        er;
   int          miscompares = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          n_done = 0;
   logic [5:0]  modes [3] = '{6'h00, 6'h08, 6'h04};
   logic [15:0] smp [3] = '{16'ha5c3, 16'h3c5a, 16'h8001};
   ////////////////////////////////////////////////////////////////////////
   // both ends face each other; recovery shortened to keep the run short
   sac_link_if lk ();
   sac_dev sac_dev_inst (.core_clk(core_clk), .arst_n(arst_n), .link(lk.dev),
      .sample_in(sample_in), .conv_done(conv_done), .napping(napping),
      .shut_down(shut_down));
   sac_host #(.REC_CYC(20)) sac_host_inst (.core_clk(core_clk), .arst_n(arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk.host));
   sac_link_assertions sac_link_assertions_inst (.core_clk(core_clk), .arst_n(arst_n),
      .convert_start_n(lk.convert_start_n), .power_down_pin(lk.power_down_pin),
      .reset_pin(lk.reset_pin), .bus_mode_select(lk.bus_mode_select),
      .byte_select_addr(lk.byte_select_addr), .cs_n(lk.cs_n), .busy(lk.busy),
      .data_out(lk.data_out), .data_oe(lk.data_oe));
   ////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (conv_done === 1'b1) begin
         n_done++;
      end
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (miscompares == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", nm, exp, got);
         miscompares++;
      end
   endtask : chk
   // one transfer; an idle cycle after it so no strobe is set twice at one edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb
   // start, poll until valid, read and compare the word
   task automatic convert(input logic [5:0] ctrl, input logic [15:0] s);
      int n;
      n = 0;
      sample_in <= s;
      apb(1'b1, REG_CTRL, {26'h0, ctrl | 6'h01});
      do begin
         apb(1'b0, REG_STAT, 32'h0);
         n++;
      end while (rd[STAT_VALID] !== 1'b1 && n < 400);
      apb(1'b0, REG_DATA, 32'h0);
      chk("result", {16'h0, s}, rd);
   endtask : convert
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      apb(1'b0, REG_CTRL, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      apb(1'b0, REG_STAT, 32'h0);
      chk("stat reset", 32'h1, rd);
      apb(1'b0, 8'h0c, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, er});
      // word, byte pair and serial in turn, the whole round run twice
      for (int i = 0; i < 6; i++) begin
         convert(modes[i % 3], smp[i % 3] ^ 16'(i));
      end
      convert(6'h10, 16'h1234);
      chk("napping", 32'h1, {31'h0, napping});
      convert(6'h10, 16'hedcb);
      apb(1'b1, REG_CTRL, 32'h2);
      repeat (8) @(posedge core_clk);
      chk("shut_down", 32'h1, {31'h0, shut_down});
      chk("oe in shutdown", 32'h0, {16'h0, lk.data_oe});
      apb(1'b1, REG_CTRL, 32'h0);
      repeat (30) @(posedge core_clk);
      chk("awake", 32'h0, {31'h0, shut_down});
      convert(6'h00, 16'h0f0f);
      // device reset pin raised in mid conversion
      apb(1'b1, REG_CTRL, 32'h1);
      repeat (3) @(posedge core_clk);
      apb(1'b1, REG_CTRL, 32'h20);
      repeat (8) @(posedge core_clk);
      chk("busy in reset", 32'h0, {31'h0, lk.busy});
      chk("oe in reset", 32'h0, {16'h0, lk.data_oe});
      apb(1'b1, REG_CTRL, 32'h0);
      repeat (40) @(posedge core_clk);
      apb(1'b0, REG_STAT, 32'h0);
      apb(1'b0, REG_DATA, 32'h0);
      convert(6'h00, 16'hc0de);
      // ten finished conversions; the aborted one must not pulse
      chk("done pulses", 32'h0000000a, n_done);
      print_verdict();
   end
endmodule : tb_sar_adc_conversion_and_readout
